// File: hw/adr_pkg.sv
// Package: register map, reset values, field layout and carriers
package adr_pkg;

  localparam int NUM_RW = 34;

  localparam logic [7:0] ADDR_CHIP_REV   = 8'h00;
  localparam logic [7:0] ADDR_CHIP_ID    = 8'h01;
  localparam logic [7:0] ADDR_FAULT      = 8'h0F;
  localparam logic [7:0] ADDR_SOFT_RST   = 8'h10;
  localparam logic [7:0] ADDR_HEAD_LOW   = 8'h45;
  localparam logic [7:0] ADDR_FRAMES_LOW = 8'h67;
  localparam logic [7:0] ADDR_FRAMES_MID = 8'h68;
  localparam logic [7:0] ADDR_FRAMES_HI  = 8'h69;
  localparam logic [7:0] ADDR_BIT_RATE   = 8'h6A;
  localparam logic [7:0] ADDR_FW_REV     = 8'h71;
  localparam logic [7:0] ADDR_SIDE_FIRST = 8'h7E;
  localparam logic [7:0] ADDR_SIDE_LAST  = 8'hB5;
  localparam int         SIDE_DEPTH      = 56;

  // Readable and writable registers, their addresses, resets and masks
  localparam logic [7:0] RW_ADDR [NUM_RW] = '{
    8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D, 8'h46, 8'h47, 8'h48, 8'h49,
    8'h4D, 8'h4E, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56,
    8'h61, 8'h63, 8'h64, 8'h65, 8'h72, 8'hB6, 8'hB8, 8'hB9, 8'hBA,
    8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC0, 8'hC1};
  localparam logic [7:0] RW_RST [NUM_RW] = '{
    8'h21, 8'h0C, 8'h00, 8'h00, 8'h04, 8'h00, 8'hFF, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h21, 8'h00,
    8'h07, 8'h00, 8'h46, 8'h5B, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00};
  localparam logic [7:0] RW_MASK [NUM_RW] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'h03, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h03, 8'h01, 8'h03,
    8'h01, 8'h1F, 8'hFF, 8'hFF, 8'h03, 8'h1F, 8'h1F};

  localparam int IDX_PLL_CTRL = 0;
  localparam int IDX_REQUEST_LINE_POLARITY  = 3;
  localparam int IDX_CLK_POL  = 4;
  localparam int IDX_OP_MODE  = 9;
  localparam int IDX_CRC_CTRL = 10;
  localparam int IDX_RUN_CTRL = 22;
  localparam int IDX_IRQ_FLAG = 23;

  localparam logic [7:0] REQUEST_LINE_POLARITY_SOFT_RST = 8'h01;
  localparam logic [5:0] FAULT_NONE       = 6'h00;

  localparam int BIT_FRAC_UPD  = 0;
  localparam int BIT_XTAL_ODIV = 1;
  localparam int BIT_XTAL_SDIV = 2;
  localparam int BIT_OSC_DIS   = 3;
  localparam int BIT_SYS_OVERSAMPLING_OUTPUT_CLOCK  = 4;
  localparam int BIT_OVERSAMPLING_OUTPUT_CLOCK_EN   = 5;
  localparam int BIT_XOUT_DIS  = 6;
  localparam int BIT_CREQ_EN   = 7;
  localparam int BIT_REQ_LOW   = 2;
  localparam int BIT_CLK_FALL  = 2;

  typedef struct packed {
    logic       sub_start;
    logic       wr_valid;
    logic [7:0] wr_data;
    logic       rd_req;
  } adr_host_t;

  typedef struct packed {
    logic [7:0]  header_low;
    logic [23:0] frame_count;
    logic [7:0]  mean_bit_rate;
    logic [7:0]  firmware_revision;
    logic        fault_valid;
    logic [5:0]  fault_code;
    logic        irq_event;
  } adr_stat_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] addr;
    logic [7:0] data;
  } adr_side_wr_t;

  typedef struct packed {
    logic       fraction_update;
    logic       crystal_to_output_divider;
    logic       crystal_to_system_divider;
    logic       oscillator_output_disable;
    logic       system_clock_to_output;
    logic       output_clock_pad_enable;
    logic       crystal_out_pad_disable;
    logic       clock_or_request_pin_enable;
    logic       request_active_low;
    logic       sample_on_falling;
    logic [1:0] operating_mode;
    logic       crc_check_control;
    logic [7:0] run_control;
    logic       interrupt_status_flag;
  } adr_ctrl_t;

  typedef struct packed {
    logic       hit;
    logic [5:0] idx;
  } adr_hit_t;

  function automatic adr_hit_t rw_lookup(input logic [7:0] a);
    adr_hit_t r;
    r = '0;
    for (int i = 0; i < NUM_RW; i++) begin
      if (RW_ADDR[i] == a) begin
        r.hit = 1'b1;
        r.idx = 6'(i);
      end
    end
    return r;
  endfunction

  function automatic logic in_side(input logic [7:0] a);
    return (a >= ADDR_SIDE_FIRST) && (a <= ADDR_SIDE_LAST);
  endfunction

endpackage

// File: hw/adr_side_mem.sv
// Side-data buffer memory with registered read data
module adr_side_mem
  import adr_pkg::*;
#(
  parameter int DEPTH = SIDE_DEPTH
) (
  input  wire logic         clk_sys_in,
  input  wire logic         sys_rst_in,
  input  wire adr_side_wr_t wr_in,
  input  wire logic [5:0]   rd_addr_in,
  output logic [7:0]        rd_data_out
);

  logic [7:0] mem_r [DEPTH];

  // No reset on the array: contents are undefined until the decoder fills it
  always_ff @(posedge clk_sys_in) begin
    if (wr_in.valid && (int'(wr_in.addr) < DEPTH)) begin
      mem_r[wr_in.addr] <= wr_in.data;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_out <= 8'h00;
    end else if (int'(rd_addr_in) < DEPTH) begin
      rd_data_out <= mem_r[rd_addr_in];
    end else begin
      rd_data_out <= 8'h00;
    end
  end

endmodule

// File: hw/adr_regs.sv
// Host register bank of the audio decoder, reached by sub-address
// Function
// [R1] Host never touches reserved addresses nor writes read-only registers.
// [R2] Host writes nothing to header, counter, rate, firmware, side-data.
// [R3] Each listed sub-address selects its own register.
// [R4] Read-only 8-bit revision at sub-address zero identifies the chip.
// [R5] Read-only identifier returns one fixed code after every reset.
// [R6] Control bit 0 set updates the PLL fraction in the switch.
// [R7] Control bit 1 routes crystal clock to output divider; hw reset clears.
// [R8] Control bit 2 routes crystal clock to system divider; hw reset clears.
// [R9] Control bit 3 disables the oscillator output; hw reset clears.
// [R10] Control bit 4 drives system clock on output clock; hw reset clears.
// [R11] Control bit 5 enables the output clock pad; hw reset sets.
// [R12] Control bit 6 disables the crystal output pad; hw reset clears.
// [R13] Control bit 7 enables shared buffered-clock or request pin.
// [R14] PLL control loads its reset value on soft and hard reset.
// [R15] PLL multiplier and divider are plain read-write, firmware managed.
// [R16] Request polarity bit 2 selects active-low request line.
// [R17] Request polarity resets to one value soft, another hard.
// [R18] Clock polarity bit 2 selects sampling on the falling edge.
// [R19] Last error kept as 6-bit code; zero none, one CRC, two data.
// [R20] Error codes also cover side data, sync, header, decoding classes.
// [R21] Any write to soft reset clears command, interrupt, idles decoder; a decoder event in the same cycle sets the interrupt flag instead.
// [R22] Address counter increments after every byte read or written.
// [R23] Host moves exactly eight bits per register access.
// [R24] Writes aimed at read-only registers are ignored.
// [R25] Error code holds until a new error or a reset.
module adr_regs
  import adr_pkg::*;
#(
  parameter logic [7:0] CHIP_REVISION = 8'h11,  // Arbitrary value
  parameter logic [7:0] CHIP_ID_CODE  = 8'h5A   // Arbitrary value
) (
  input  wire logic         clk_sys_in,
  input  wire logic         sys_rst_in,
  input  wire adr_host_t    host_in,
  output logic [7:0]        rd_data_out,
  output logic              rd_valid_out,
  input  wire adr_stat_t    stat_in,
  input  wire adr_side_wr_t side_wr_in,
  output adr_ctrl_t         ctrl_out,
  output logic [8*NUM_RW-1:0] cfg_bytes_out,
  output logic              decoder_idle_out
);

  logic [7:0] rw_r [NUM_RW];
  logic [7:0] ptr_r;
  logic       addr_phase_r;
  logic [5:0] fault_r;
  logic       rd_stage_r;
  logic       rd_mem_sel_r;
  logic [7:0] rd_hold_r;
  logic [7:0] rd_data_r;
  logic       rd_valid_r;
  logic       idle_r;
  logic [7:0] mem_q;
  logic [7:0] rd_nxt;
  logic [5:0] side_idx;
  logic       addr_now;
  logic       data_wr;
  logic       soft_hit;
  adr_hit_t   wr_hit;
  adr_hit_t   rd_hit;

  // The first byte written after a start is the sub-address, not data
  assign addr_now = addr_phase_r | host_in.sub_start;
  assign data_wr  = host_in.wr_valid & ~addr_now;
  assign wr_hit   = rw_lookup(ptr_r);
  assign rd_hit   = rw_lookup(ptr_r);
  assign soft_hit = data_wr && (ptr_r == ADDR_SOFT_RST); // [R21]
  assign side_idx = 6'(ptr_r - ADDR_SIDE_FIRST);

  // Address counter and sub-address capture
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ptr_r        <= 8'h00;
      addr_phase_r <= 1'b0;
    end else begin
      if (host_in.wr_valid && addr_now) begin
        ptr_r        <= host_in.wr_data; // [R3]
        addr_phase_r <= 1'b0;
      end else if (host_in.wr_valid || host_in.rd_req) begin
        ptr_r        <= ptr_r + 8'h01; // [R22]
        addr_phase_r <= addr_now;
      end else begin
        addr_phase_r <= addr_now;
      end
    end
  end

  // Writable registers; soft reset reloads only its own subset
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NUM_RW; i++) begin
        rw_r[i] <= RW_RST[i]; // [R14] [R7] [R8] [R9] [R10] [R11] [R12]
      end
    end else begin
      if (soft_hit) begin
        rw_r[IDX_PLL_CTRL] <= RW_RST[IDX_PLL_CTRL]; // [R14]
        rw_r[IDX_REQUEST_LINE_POLARITY]  <= REQUEST_LINE_POLARITY_SOFT_RST; // [R17]
        rw_r[IDX_CLK_POL]  <= RW_RST[IDX_CLK_POL];
        rw_r[IDX_RUN_CTRL] <= RW_RST[IDX_RUN_CTRL]; // [R21]
        rw_r[IDX_IRQ_FLAG] <= RW_RST[IDX_IRQ_FLAG]; // [R21]
      end else if (data_wr && wr_hit.hit) begin
        // Only mapped writable entries take data; all else is dropped
        rw_r[wr_hit.idx] <= host_in.wr_data & RW_MASK[wr_hit.idx]; // [R24]
      end
      // Decoder event wins over a clear in the same cycle
      if (stat_in.irq_event) begin
        rw_r[IDX_IRQ_FLAG] <= 8'h01;
      end
    end
  end

  // Last fault code; a new error beats a simultaneous soft reset
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fault_r <= FAULT_NONE;
    end else if (stat_in.fault_valid) begin
      fault_r <= stat_in.fault_code; // [R19] [R20]
    end else if (soft_hit) begin
      fault_r <= FAULT_NONE; // [R25]
    end
  end

  // Idle command to the decoder core
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idle_r <= 1'b0;
    end else begin
      idle_r <= soft_hit; // [R21]
    end
  end

  // Read selection for everything that is not the side-data memory
  always_comb begin
    rd_nxt = 8'h00;
    unique case (ptr_r)
      ADDR_CHIP_REV:   rd_nxt = CHIP_REVISION; // [R4]
      ADDR_CHIP_ID:    rd_nxt = CHIP_ID_CODE; // [R5]
      ADDR_FAULT:      rd_nxt = {2'b00, fault_r}; // [R19]
      ADDR_HEAD_LOW:   rd_nxt = stat_in.header_low;
      ADDR_FRAMES_LOW: rd_nxt = stat_in.frame_count[7:0];
      ADDR_FRAMES_MID: rd_nxt = stat_in.frame_count[15:8];
      ADDR_FRAMES_HI:  rd_nxt = stat_in.frame_count[23:16];
      ADDR_BIT_RATE:   rd_nxt = stat_in.mean_bit_rate;
      ADDR_FW_REV:     rd_nxt = stat_in.firmware_revision;
      default: begin
        // Unmapped and write-only addresses read as zero
        if (rd_hit.hit) begin
          rd_nxt = rw_r[rd_hit.idx] & RW_MASK[rd_hit.idx]; // [R3] [R15]
        end
      end
    endcase
  end

  // Two-stage read so that memory and register data leave from flops
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_stage_r   <= 1'b0;
      rd_mem_sel_r <= 1'b0;
      rd_hold_r    <= 8'h00;
    end else begin
      rd_stage_r <= host_in.rd_req & ~host_in.wr_valid;
      if (host_in.rd_req) begin
        rd_mem_sel_r <= in_side(ptr_r);
        rd_hold_r    <= rd_nxt;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_stage_r;
      if (rd_stage_r) begin
        rd_data_r <= rd_mem_sel_r ? mem_q : rd_hold_r;
      end
    end
  end

  adr_side_mem #(
    .DEPTH (SIDE_DEPTH)
  ) u_side_mem (
    .clk_sys_in  (clk_sys_in),
    .sys_rst_in  (sys_rst_in),
    .wr_in       (side_wr_in),
    .rd_addr_in  (side_idx),
    .rd_data_out (mem_q)
  );

  assign rd_data_out      = rd_data_r;
  assign rd_valid_out     = rd_valid_r;
  assign decoder_idle_out = idle_r;

  // Control fields drawn straight from the stored bytes
  assign ctrl_out.fraction_update             =
    rw_r[IDX_PLL_CTRL][BIT_FRAC_UPD]; // [R6]
  assign ctrl_out.crystal_to_output_divider   =
    rw_r[IDX_PLL_CTRL][BIT_XTAL_ODIV]; // [R7]
  assign ctrl_out.crystal_to_system_divider   =
    rw_r[IDX_PLL_CTRL][BIT_XTAL_SDIV]; // [R8]
  assign ctrl_out.oscillator_output_disable   =
    rw_r[IDX_PLL_CTRL][BIT_OSC_DIS]; // [R9]
  assign ctrl_out.system_clock_to_output      =
    rw_r[IDX_PLL_CTRL][BIT_SYS_OVERSAMPLING_OUTPUT_CLOCK]; // [R10]
  assign ctrl_out.output_clock_pad_enable     =
    rw_r[IDX_PLL_CTRL][BIT_OVERSAMPLING_OUTPUT_CLOCK_EN]; // [R11]
  assign ctrl_out.crystal_out_pad_disable     =
    rw_r[IDX_PLL_CTRL][BIT_XOUT_DIS]; // [R12]
  assign ctrl_out.clock_or_request_pin_enable =
    rw_r[IDX_PLL_CTRL][BIT_CREQ_EN]; // [R13]
  assign ctrl_out.request_active_low          =
    rw_r[IDX_REQUEST_LINE_POLARITY][BIT_REQ_LOW]; // [R16]
  assign ctrl_out.sample_on_falling           =
    rw_r[IDX_CLK_POL][BIT_CLK_FALL]; // [R18]
  assign ctrl_out.operating_mode        = rw_r[IDX_OP_MODE][1:0];
  assign ctrl_out.crc_check_control     = rw_r[IDX_CRC_CTRL][0];
  assign ctrl_out.run_control           = rw_r[IDX_RUN_CTRL];
  assign ctrl_out.interrupt_status_flag = rw_r[IDX_IRQ_FLAG][0];

  always_comb begin
    for (int i = 0; i < NUM_RW; i++) begin
      cfg_bytes_out[8*i +: 8] = rw_r[i];
    end
  end

  a_subaddr_load: assert property (@(posedge clk_sys_in) // [R3]
    disable iff (sys_rst_in)
    (host_in.wr_valid && addr_now) |=> (ptr_r == $past(host_in.wr_data)))
    else $error("sub-address not loaded");

  a_ptr_step: assert property (@(posedge clk_sys_in) // [R22]
    disable iff (sys_rst_in)
    (data_wr || (host_in.rd_req && !host_in.wr_valid))
      |=> (ptr_r == $past(ptr_r) + 8'h01))
    else $error("address counter did not step");

  a_read_latency: assert property (@(posedge clk_sys_in) // [R3]
    disable iff (sys_rst_in)
    (host_in.rd_req && !host_in.wr_valid) |-> ##2 rd_valid_out)
    else $error("read answer late or missing");

  a_ident_fixed: assert property (@(posedge clk_sys_in) // [R5]
    disable iff (sys_rst_in)
    (host_in.rd_req && !host_in.wr_valid && ptr_r == ADDR_CHIP_ID)
      |-> ##2 (rd_data_out == CHIP_ID_CODE))
    else $error("identifier read wrong");

  a_pll_soft_load: assert property (@(posedge clk_sys_in) // [R14]
    disable iff (sys_rst_in)
    soft_hit |=> (cfg_bytes_out[8*IDX_PLL_CTRL +: 8] == 8'h21))
    else $error("pll control not reloaded");

  a_reqpol_soft: assert property (@(posedge clk_sys_in) // [R17]
    disable iff (sys_rst_in)
    soft_hit |=> (cfg_bytes_out[8*IDX_REQUEST_LINE_POLARITY +: 8] == 8'h01)
      && !ctrl_out.request_active_low)
    else $error("request polarity soft value wrong");

  a_soft_idle: assert property (@(posedge clk_sys_in) // [R21]
    disable iff (sys_rst_in)
    (soft_hit && !stat_in.irq_event) |=> decoder_idle_out
      && (ctrl_out.run_control == 8'h00) && !ctrl_out.interrupt_status_flag
      ##1 !decoder_idle_out)
    else $error("soft reset effects missing");

  a_fault_capture: assert property (@(posedge clk_sys_in) // [R19]
    disable iff (sys_rst_in)
    stat_in.fault_valid |=> (fault_r == $past(stat_in.fault_code)))
    else $error("fault code not captured");

  a_fault_hold: assert property (@(posedge clk_sys_in) // [R25]
    disable iff (sys_rst_in)
    (!stat_in.fault_valid && !soft_hit) |=> $stable(fault_r))
    else $error("fault code changed without cause");

  a_ro_ignored: assert property (@(posedge clk_sys_in) // [R24]
    disable iff (sys_rst_in)
    (data_wr && !wr_hit.hit && !soft_hit && !stat_in.irq_event)
      |=> (cfg_bytes_out == $past(cfg_bytes_out)))
    else $error("write to read-only address changed state");

endmodule

// File: dv/adr_host_model.sv
// Host byte engine model: sub-address, data bytes and one-byte reads
module adr_host_model
  import adr_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in,
  output adr_host_t       host_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial host_out = '0;

  // One request per call, held across one full edge, then released
  task automatic drive(input logic s, input logic w, input logic r,
                       input logic [7:0] d);
    @(posedge clk_sys_in);
    #1;
    host_out.sub_start = s;
    host_out.wr_valid  = w;
    host_out.rd_req    = r;
    host_out.wr_data   = d;
    @(posedge clk_sys_in);
    #1;
    // Released data shows the inverse, so no stale byte can pass for valid
    host_out = {1'b0, 1'b0, ~d, 1'b0};
  endtask

  task automatic set_addr(input logic [7:0] a);
    drive(1'b1, 1'b1, 1'b0, a);
  endtask

  task automatic wr(input logic [7:0] d);
    drive(1'b0, 1'b1, 1'b0, d);
  endtask

  task automatic rd(output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d  = 'x;
    drive(1'b0, 1'b0, 1'b1, host_out.wr_data);
    // The answer pulse comes one edge after the request is released
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rd_valid_in === 1'b1) begin
        ok = 1'b1;
        d  = rd_data_in;
      end else begin
        @(posedge clk_sys_in);
        #1;
      end
    end
  endtask
endmodule

// File: dv/test_adr_regs.sv
// Self-checking bench for the decoder host register bank
module test_adr_regs;
  import adr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] REV = 8'h11;  // Arbitrary value
  localparam logic [7:0] IDC = 8'h5A;  // Arbitrary value

  logic                clk_sys_in;
  logic                sys_rst_in;
  adr_host_t           host_bus;
  logic [7:0]          rd_data;
  logic                rd_valid;
  adr_stat_t           stat;
  adr_side_wr_t        side_wr;
  adr_ctrl_t           ctrl;
  logic [8*NUM_RW-1:0] cfg;
  logic                idle;
  int                  failures;
  int                  checked;
  logic [7:0]          v;
  bit                  ok;
  logic [5:0]          codes [6] = '{6'h01, 6'h02, 6'h04, 6'h10, 6'h23, 6'h3F};

  adr_regs #(.CHIP_REVISION(REV), .CHIP_ID_CODE(IDC)) dut (
    .clk_sys_in      (clk_sys_in),
    .sys_rst_in      (sys_rst_in),
    .host_in         (host_bus),
    .rd_data_out     (rd_data),
    .rd_valid_out    (rd_valid),
    .stat_in         (stat),
    .side_wr_in      (side_wr),
    .ctrl_out        (ctrl),
    .cfg_bytes_out   (cfg),
    .decoder_idle_out(idle)
  );

  adr_host_model host_m (
    .clk_sys_in (clk_sys_in),
    .rd_data_in (rd_data),
    .rd_valid_in(rd_valid),
    .host_out   (host_bus)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask

  // A missing answer ends the run at once
  task automatic rd_chk(input string what, input logic [7:0] exp);
    host_m.rd(v, ok);
    if (!ok) begin
      failures++;
      stop_test();
    end
    check(what, exp, v);
  endtask

  task automatic rd_at(input string what, input logic [7:0] a,
                       input logic [7:0] exp);
    host_m.set_addr(a);
    rd_chk(what, exp);
  endtask

  task automatic fault(input logic [5:0] c);
    tick();
    stat.fault_valid = 1'b1;
    stat.fault_code  = c;
    tick();
    stat.fault_valid = 1'b0;
  endtask

  function automatic logic [7:0] pll_bits();
    return {ctrl.clock_or_request_pin_enable, ctrl.crystal_out_pad_disable,
            ctrl.output_clock_pad_enable, ctrl.system_clock_to_output,
            ctrl.oscillator_output_disable, ctrl.crystal_to_system_divider,
            ctrl.crystal_to_output_divider, ctrl.fraction_update};
  endfunction

  initial begin
    failures   = 0;
    checked    = 0;
    sys_rst_in = 1'b1;
    side_wr    = '0;
    stat       = {8'h9C, 24'h123456, 8'h80, 8'h27, 1'b0, 6'h00, 1'b0};
    repeat (4) @(posedge clk_sys_in);
    #1;
    sys_rst_in = 1'b0;
    check("pll pins", RW_RST[IDX_PLL_CTRL], pll_bits());
    rd_at("revision", ADDR_CHIP_REV, REV);
    rd_chk("identifier", IDC);
    for (int i = 0; i < NUM_RW; i++) begin
      rd_at("reset value", RW_ADDR[i], RW_RST[i]);
    end
    for (int i = 0; i < NUM_RW; i++) begin
      host_m.set_addr(RW_ADDR[i]);
      host_m.wr(8'hA5 ^ 8'(i));
      rd_at("readback", RW_ADDR[i], (8'hA5 ^ 8'(i)) & RW_MASK[i]);
    end
    // Complement of the reset pattern, so every control bit flips
    host_m.set_addr(8'h05);
    host_m.wr(8'hDE);
    host_m.wr(8'h12);
    host_m.wr(8'h34);
    tick();
    check("pll pins", 8'hDE, pll_bits());
    rd_at("burst", 8'h05, 8'hDE);
    rd_chk("burst", 8'h12);
    rd_chk("burst", 8'h34);
    for (int k = 0; k < 2; k++) begin
      host_m.set_addr(8'h0C);
      host_m.wr(k ? 8'h01 : 8'h05);
      host_m.wr(k ? 8'h04 : 8'h00);
      tick();
      check("request low", 8'(k ? 0 : 1), 8'(ctrl.request_active_low));
      check("falling", 8'(k), 8'(ctrl.sample_on_falling));
    end
    host_m.set_addr(ADDR_CHIP_ID);
    host_m.wr(8'hFF);
    rd_at("identifier", ADDR_CHIP_ID, IDC);
    host_m.set_addr(ADDR_FAULT);
    host_m.wr(8'h3F);
    rd_at("fault", ADDR_FAULT, 8'h00);
    rd_at("reserved", 8'h02, 8'h00);
    rd_at("wrap", 8'hFF, 8'h00);
    rd_chk("wrap", REV);
    tick();
    side_wr = '{1'b1, 6'd0, 8'h3C};
    tick();
    side_wr = '{1'b1, 6'd55, 8'hC3};
    tick();
    side_wr = '0;
    rd_at("side first", ADDR_SIDE_FIRST, 8'h3C);
    rd_at("side last", ADDR_SIDE_LAST, 8'hC3);
    rd_at("header", ADDR_HEAD_LOW, 8'h9C);
    rd_at("frames", ADDR_FRAMES_LOW, 8'h56);
    rd_chk("frames", 8'h34);
    rd_chk("frames", 8'h12);
    rd_chk("bit rate", 8'h80);
    rd_at("firmware", ADDR_FW_REV, 8'h27);
    // Live status fields flip every bit, so no stuck read path can pass
    stat.header_low        = 8'h63;
    stat.frame_count       = 24'hEDCBA9;
    stat.mean_bit_rate     = 8'h7F;
    stat.firmware_revision = 8'hD8;
    rd_at("header", ADDR_HEAD_LOW, 8'h63);
    rd_at("frames", ADDR_FRAMES_LOW, 8'hA9);
    rd_chk("frames", 8'hCB);
    rd_chk("frames", 8'hED);
    rd_chk("bit rate", 8'h7F);
    rd_at("firmware", ADDR_FW_REV, 8'hD8);
    rd_at("soft reset reg", ADDR_SOFT_RST, 8'h00);
    foreach (codes[i]) begin
      fault(codes[i]);
      rd_at("fault", ADDR_FAULT, 8'(codes[i]));
    end
    repeat (5) tick();
    rd_at("fault held", ADDR_FAULT, 8'h3F);
    tick();
    stat.irq_event = 1'b1;
    tick();
    stat.irq_event = 1'b0;
    tick();
    check("irq flag", 8'h01, 8'(ctrl.interrupt_status_flag));
    host_m.set_addr(8'h72);
    host_m.wr(8'h5A);
    host_m.set_addr(8'h05);
    host_m.wr(8'hFE);
    host_m.set_addr(8'h0C);
    host_m.wr(8'h05);
    host_m.wr(8'h00);
    host_m.set_addr(ADDR_SOFT_RST);
    host_m.wr(8'h00);
    check("idle pulse", 8'h01, 8'(idle));
    tick();
    check("idle pulse", 8'h00, 8'(idle));
    rd_at("pll soft", 8'h05, 8'h21);
    rd_at("req soft", 8'h0C, REQUEST_LINE_POLARITY_SOFT_RST);
    rd_chk("clk soft", 8'h04);
    rd_at("run soft", 8'h72, 8'h00);
    rd_at("irq soft", 8'hB6, 8'h00);
    rd_at("fault soft", ADDR_FAULT, 8'h00);
    rd_at("kept", 8'h46, 8'hA0);
    // Move control away from its reset value so the hard reset shows
    host_m.set_addr(8'h05);
    host_m.wr(8'hDE);
    sys_rst_in = 1'b1;
    repeat (2) tick();
    sys_rst_in = 1'b0;
    check("pll pins", 8'h21, pll_bits());
    rd_at("req hard", 8'h0C, 8'h00);
    stop_test();
  end
endmodule
